/* design/efs_pkg.sv */
package efs_pkg;

   // ----------------------------------------
   // Register map (byte addresses)
   // ----------------------------------------
   localparam logic [31:0] ADDR_STATUS = 32'h0000_00c8;
   localparam logic [31:0] ADDR_MASK = 32'h0000_00cc;
   localparam logic [31:0] ADDR_MSG_CNT = 32'h0000_00d0;
   localparam logic [31:0] ADDR_CAUSE = 32'h0000_00d4;

   // ----------------------------------------
   // Reset values and field layout
   // ----------------------------------------
   localparam logic [15:0] STATUS_RESET = 16'h0000;
   localparam logic [15:0] MASK_RESET = 16'h0000;
   localparam logic [15:0] MSG_CNT_RESET = 16'h0000;
   localparam logic [15:0] CAUSE_RESET = 16'h0000;
   localparam logic [15:0] FLAG_IMPL = 16'h033e; // Implemented flag bits
   localparam int unsigned BIT_LOCK = 9;
   localparam int unsigned BIT_SMI = 8;
   localparam int unsigned BIT_USC = 5;
   localparam int unsigned BIT_OOA = 4;
   localparam int unsigned BIT_IAA = 3;
   localparam int unsigned BIT_BTE = 2;
   localparam int unsigned BIT_CMD = 1;

   // ----------------------------------------
   // Bus encodings and states
   // ----------------------------------------
   localparam logic [2:0] HSIZE_WORD = 3'h2;
   localparam logic HRESP_OKAY = 1'b0;

   typedef enum logic [1:0] {
      EFS_ST_IDLE = 2'h0,
      EFS_ST_WRITE = 2'h1,
      EFS_ST_RD_WAIT = 2'h3,
      EFS_ST_RD_DATA = 2'h2
   } efs_bus_state_type;

endpackage

/* design/efs_ahb_port.sv */
`timescale 1ns/1ns
`default_nettype none

module efs_ahb_port (
   input wire logic i_core_clk, // Core clock
   input wire logic i_rst_n, // Async reset, active low
   input wire logic i_hsel, // Slave select
   input wire logic [31:0] i_haddr, // Byte address
   input wire logic [1:0] i_htrans, // Transfer type
   input wire logic i_hwrite, // Write when high
   input wire logic [2:0] i_hsize, // Transfer size
   input wire logic [31:0] i_hwdata, // Write data
   input wire logic i_hready, // Bus ready
   output logic [31:0] o_hrdata, // Read data
   output logic o_hreadyout, // Slave ready
   output logic o_hresp, // Always OKAY
   output logic o_wr_en, // Register write strobe
   output logic [31:0] o_addr, // Captured address
   output logic [31:0] o_wr_data, // Write data
   input wire logic [31:0] i_rd_data // Read mux value
);

   typedef struct packed {
      efs_pkg::efs_bus_state_type st;
      logic [31:0] addr;
      logic [31:0] rdata;
   } efs_port_state_type;

   efs_port_state_type r_reg;
   efs_port_state_type r_next;
   logic take;

   // ----------------------------------------
   // Transfer sequencing
   // ----------------------------------------
   // Reads take one wait state so that hrdata comes from a flop
   assign take = i_hsel && i_htrans[1] && i_hready;

   always_comb begin
      r_next = r_reg;
      case (r_reg.st)
         efs_pkg::EFS_ST_RD_WAIT: begin
            r_next.st = efs_pkg::EFS_ST_RD_DATA;
            r_next.rdata = i_rd_data;
         end
         default: begin
            if (take) begin
               r_next.addr = i_haddr;
               if (!i_hwrite) begin
                  r_next.st = efs_pkg::EFS_ST_RD_WAIT;
               end else if (i_hsize == efs_pkg::HSIZE_WORD) begin
                  r_next.st = efs_pkg::EFS_ST_WRITE;
               end else begin
                  r_next.st = efs_pkg::EFS_ST_IDLE; // Narrow writes dropped
               end
            end else begin
               r_next.st = efs_pkg::EFS_ST_IDLE;
            end
         end
      endcase
   end

   always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         r_reg <= '{efs_pkg::EFS_ST_IDLE, 32'h0000_0000, 32'h0000_0000};
      end else begin
         r_reg <= r_next;
      end
   end

   // Outputs
   assign o_hrdata = r_reg.rdata;
   assign o_hreadyout = (r_reg.st != efs_pkg::EFS_ST_RD_WAIT);
   assign o_hresp = efs_pkg::HRESP_OKAY;
   assign o_wr_en = (r_reg.st == efs_pkg::EFS_ST_WRITE);
   assign o_addr = r_reg.addr;
   assign o_wr_data = i_hwdata;

endmodule

`default_nettype wire

/* design/efs_msg_queue.sv */
`timescale 1ns/1ns
`default_nettype none

module efs_msg_queue #(
   parameter int unsigned CNT_W = 4 // Pending counter width
) (
   input wire logic i_core_clk, // Core clock
   input wire logic i_rst_n, // Async reset, active low
   input wire logic i_req, // One message wanted
   output logic o_msg_valid, // Message offered to link
   input wire logic i_msg_ready, // Link takes message
   output logic o_sent, // Message handed over
   output logic [CNT_W-1:0] o_pending // Messages still owed
);

   typedef struct packed {
      logic [CNT_W-1:0] pend;
   } efs_queue_state_type;

   efs_queue_state_type r_reg;
   efs_queue_state_type r_next;

   // ----------------------------------------
   // Owed-message counter
   // ----------------------------------------
   // Request and send in one cycle cancel, so none is lost
   always_comb begin
      r_next = r_reg;
      if (i_req && !o_sent && !(&r_reg.pend)) begin
         r_next.pend = r_reg.pend + {{(CNT_W-1){1'b0}}, 1'b1};
      end else if (!i_req && o_sent) begin
         r_next.pend = r_reg.pend - {{(CNT_W-1){1'b0}}, 1'b1};
      end
   end

   always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         r_reg <= '0;
      end else begin
         r_reg <= r_next;
      end
   end

   assign o_msg_valid = (r_reg.pend != '0);
   assign o_sent = o_msg_valid && i_msg_ready;
   assign o_pending = r_reg.pend;

endmodule

`default_nettype wire

/* design/efs_error_flags.sv */
`timescale 1ns/1ns
`default_nettype none

// Functional notes
// - Flags set on detection, regardless of reporting.
// - One message per cycle in which any enabled flag rises.
// - Writing one clears a flag; zero keeps.
// - Bit 9: lock outside system memory.
// - Bit 8: SMI from graphics software trigger.
// - Bit 5: unknown hub link special cycle.
// - Bit 4: AGP access outside aperture.
// - Bit 3: outside aperture, legacy or above top.
// - Bit 2: bad translation entry inside aperture.
// - Bit 1: malformed or unsupported AGP command.
// - Message needs flag and global enables.

module efs_error_flags #(
   parameter int unsigned QUEUE_W = 4 // Owed message counter width
) (
   input wire logic i_core_clk, // Core clock, 125 MHz
   input wire logic i_rst_n, // Async reset, active low
   // AHB-Lite slave
   input wire logic i_hsel, // Slave select
   input wire logic [31:0] i_haddr, // Byte address
   input wire logic [1:0] i_htrans, // Transfer type
   input wire logic i_hwrite, // Write when high
   input wire logic [2:0] i_hsize, // Transfer size
   input wire logic [31:0] i_hwdata, // Write data
   input wire logic i_hready, // Bus ready
   output logic [31:0] o_hrdata, // Read data
   output logic o_hreadyout, // Slave ready
   output logic o_hresp, // Response, always OKAY
   // Error detections, one-cycle pulses
   input wire logic i_lock_miss_evt, // Lock not in system memory
   input wire logic i_smi_evt, // SMI raised
   input wire logic i_smi_from_sw, // SMI source is graphics trigger
   input wire logic i_special_cycle_evt, // Unknown special cycle seen
   input wire logic i_agp_access_evt, // AGP access decoded
   input wire logic i_agp_outside_aperture, // Access misses aperture
   input wire logic i_agp_legacy_hit, // Access in 640 KB..1 MB
   input wire logic i_agp_above_tom, // Access above top of memory
   input wire logic i_agp_bad_entry, // Translation entry invalid
   input wire logic i_agp_bad_cmd_evt, // Bad AGP command
   // Enables held in other registers
   input wire logic [15:0] i_error_report_enables, // Per-flag enables
   input wire logic i_function_command_serr_en, // Global enable
   // Hub link message and interrupt
   output logic o_serr_msg_valid, // Error message offered
   input wire logic i_serr_msg_ready, // Hub link takes it
   output logic o_irq, // Level interrupt
   output logic [15:0] o_error_flag_status // Flag register view
);

   // ----------------------------------------
   // State
   // ----------------------------------------
   typedef struct packed {
      logic [15:0] flags;
      logic [15:0] mask;
      logic [15:0] msg_cnt;
      logic [15:0] cause;
   } efs_flag_state_type;

   efs_flag_state_type r_reg;
   efs_flag_state_type r_next;

   logic wr_en;
   logic [31:0] addr;
   logic [31:0] wr_data;
   logic [31:0] rd_data;
   logic [15:0] set_vec;
   logic [15:0] clr_vec;
   logic [15:0] rise_vec;
   logic [15:0] report_vec;
   logic msg_req;
   logic msg_sent;
   logic [QUEUE_W-1:0] pending;

   // ----------------------------------------
   // Functions
   // ----------------------------------------
   // Exact word match on the full address
   function automatic logic hit(input logic [31:0] a, input logic [31:0] base);
      hit = (a == base);
   endfunction

   // Read mux; unmapped words read as zero
   function automatic logic [31:0] read_word(input logic [31:0] a,
                                             input efs_flag_state_type s,
                                             input logic [15:0] pend);
      read_word = 32'h0000_0000;
      if (hit(a, efs_pkg::ADDR_STATUS)) begin
         read_word = {16'h0000, s.flags & efs_pkg::FLAG_IMPL};
      end else if (hit(a, efs_pkg::ADDR_MASK)) begin
         read_word = {16'h0000, s.mask};
      end else if (hit(a, efs_pkg::ADDR_MSG_CNT)) begin
         read_word = {pend, s.msg_cnt};
      end else if (hit(a, efs_pkg::ADDR_CAUSE)) begin
         read_word = {16'h0000, s.cause};
      end
   endfunction

   // ----------------------------------------
   // Bus front end
   // ----------------------------------------
   efs_ahb_port u_port (
      .i_core_clk(i_core_clk),
      .i_rst_n(i_rst_n),
      .i_hsel(i_hsel),
      .i_haddr(i_haddr),
      .i_htrans(i_htrans),
      .i_hwrite(i_hwrite),
      .i_hsize(i_hsize),
      .i_hwdata(i_hwdata),
      .i_hready(i_hready),
      .o_hrdata(o_hrdata),
      .o_hreadyout(o_hreadyout),
      .o_hresp(o_hresp),
      .o_wr_en(wr_en),
      .o_addr(addr),
      .o_wr_data(wr_data),
      .i_rd_data(rd_data)
   );

   assign rd_data = read_word(addr, r_reg, {{(16-QUEUE_W){1'b0}}, pending});

   // ----------------------------------------
   // Detection to flag bits
   // ----------------------------------------
   // Enables are not looked at here: flags record every event
   always_comb begin
      set_vec = 16'h0000;
      set_vec[efs_pkg::BIT_LOCK] = i_lock_miss_evt;
      set_vec[efs_pkg::BIT_SMI] = i_smi_evt && i_smi_from_sw;
      set_vec[efs_pkg::BIT_USC] = i_special_cycle_evt;
      set_vec[efs_pkg::BIT_OOA] = i_agp_access_evt && i_agp_outside_aperture;
      set_vec[efs_pkg::BIT_IAA] = i_agp_access_evt && i_agp_outside_aperture
                                  && (i_agp_legacy_hit || i_agp_above_tom);
      set_vec[efs_pkg::BIT_BTE] = i_agp_access_evt && !i_agp_outside_aperture
                                  && i_agp_bad_entry;
      set_vec[efs_pkg::BIT_CMD] = i_agp_bad_cmd_evt;
   end

   // Ones written to the flag word clear; zeros do nothing
   assign clr_vec = (wr_en && hit(addr, efs_pkg::ADDR_STATUS)) ?
                    (wr_data[15:0] & efs_pkg::FLAG_IMPL) : 16'h0000;

   // ----------------------------------------
   // Next state
   // ----------------------------------------
   always_comb begin
      r_next = r_reg;
      // Set beats clear in the same cycle, so no event is lost
      r_next.flags = ((r_reg.flags & ~clr_vec) | set_vec) & efs_pkg::FLAG_IMPL;
      if (wr_en && hit(addr, efs_pkg::ADDR_MASK)) begin
         r_next.mask = wr_data[15:0] & efs_pkg::FLAG_IMPL;
      end
      if (msg_sent) begin
         r_next.msg_cnt = r_reg.msg_cnt + 16'h0001;
      end
      if (msg_req) begin
         r_next.cause = report_vec;
      end
   end

   // Only a true 0-to-1 change counts; a flag already set stays quiet
   assign rise_vec = r_next.flags & ~r_reg.flags;
   assign report_vec = rise_vec & i_error_report_enables & efs_pkg::FLAG_IMPL;
   // Several flags rising together yield one message
   assign msg_req = i_function_command_serr_en && (report_vec != 16'h0000);

   always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         r_reg <= '{efs_pkg::STATUS_RESET, efs_pkg::MASK_RESET,
                    efs_pkg::MSG_CNT_RESET, efs_pkg::CAUSE_RESET};
      end else begin
         r_reg <= r_next;
      end
   end

   // ----------------------------------------
   // Hub link message queue
   // ----------------------------------------
   // A slow link must not swallow messages, so owed ones are counted
   efs_msg_queue #(
      .CNT_W(QUEUE_W)
   ) u_queue (
      .i_core_clk(i_core_clk),
      .i_rst_n(i_rst_n),
      .i_req(msg_req),
      .o_msg_valid(o_serr_msg_valid),
      .i_msg_ready(i_serr_msg_ready),
      .o_sent(msg_sent),
      .o_pending(pending)
   );

   // Outputs
   assign o_irq = ((r_reg.flags & r_reg.mask) != 16'h0000);
   assign o_error_flag_status = r_reg.flags;

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   logic [15:0] clr_only;
   logic [15:0] keep_vec;

   // Helpers: bits cleared without a competing set, bits kept
   assign clr_only = clr_vec & ~set_vec;
   assign keep_vec = r_reg.flags & ~clr_vec;

   default clocking cb @(posedge i_core_clk);
   endclocking
   default disable iff (!i_rst_n);

   AST_SET_ANYWAY:
      assert property ((set_vec != 16'h0000) |=>
                       ((r_reg.flags & $past(set_vec)) == $past(set_vec)))
      else $error("detected event did not set its flag");

   AST_MSG_ON_RISE:
      assert property ((msg_req && pending == '0) |=> o_serr_msg_valid)
      else $error("enabled flag rise sent no message");

   // Cause bits of a fresh message must be flags that just went 0-to-1
   AST_NO_MSG_WITHOUT_RISE:
      assert property ($rose(o_serr_msg_valid) |->
                       ((r_reg.cause != 16'h0000) &&
                        ((r_reg.cause & ~r_reg.flags) == 16'h0000) &&
                        ((r_reg.cause & $past(r_reg.flags)) == 16'h0000)))
      else $error("message without a flag rising");

   AST_W1C_CLEARS:
      assert property ((clr_only != 16'h0000) |=>
                       ((r_reg.flags & $past(clr_only)) == 16'h0000))
      else $error("write of one did not clear flag");

   AST_W0_KEEPS:
      assert property (1'b1 |=> ((r_reg.flags & $past(keep_vec)) == $past(keep_vec)))
      else $error("flag dropped without a clearing write");

   AST_LOCK_FLAG:
      assert property (i_lock_miss_evt |=> r_reg.flags[efs_pkg::BIT_LOCK])
      else $error("lock miss did not set bit 9");

   AST_SMI_FLAG:
      assert property ((!(i_smi_evt && i_smi_from_sw) && !r_reg.flags[efs_pkg::BIT_SMI])
                       |=> !r_reg.flags[efs_pkg::BIT_SMI])
      else $error("bit 8 set without software SMI");

   AST_SPECIAL_FLAG:
      assert property (i_special_cycle_evt |=> r_reg.flags[efs_pkg::BIT_USC])
      else $error("unknown special cycle did not set bit 5");

   AST_OUTSIDE_FLAG:
      assert property ((i_agp_access_evt && i_agp_outside_aperture)
                       |=> r_reg.flags[efs_pkg::BIT_OOA])
      else $error("outside aperture access did not set bit 4");

   AST_ILLEGAL_FLAG:
      assert property ((!r_reg.flags[efs_pkg::BIT_IAA] &&
                        !(i_agp_access_evt && i_agp_outside_aperture))
                       |=> !r_reg.flags[efs_pkg::BIT_IAA])
      else $error("bit 3 set without outside access");

   AST_ENTRY_FLAG:
      assert property ((i_agp_access_evt && !i_agp_outside_aperture && i_agp_bad_entry)
                       |=> r_reg.flags[efs_pkg::BIT_BTE])
      else $error("bad translation entry did not set bit 2");

   AST_CMD_FLAG:
      assert property (i_agp_bad_cmd_evt |=> r_reg.flags[efs_pkg::BIT_CMD])
      else $error("bad AGP command did not set bit 1");

   // Looks at the registers, not at the request term it guards
   AST_NEEDS_ENABLES:
      assert property ($rose(o_serr_msg_valid) |->
                       ($past(i_function_command_serr_en) &&
                        (($past(i_error_report_enables) & r_reg.flags & ~$past(r_reg.flags))
                         != 16'h0000)))
      else $error("message sent without enables");

   AST_RESERVED_ZERO:
      assert property ((r_reg.flags & ~efs_pkg::FLAG_IMPL) == 16'h0000)
      else $error("reserved flag bit is set");

   // ----------------------------------------
   // Further flag and message checks
   // ----------------------------------------
   // Positive side of the qualified detectors
   AST_SMI_SETS:
      assert property ((i_smi_evt && i_smi_from_sw) |=> r_reg.flags[efs_pkg::BIT_SMI])
      else $error("software SMI did not set bit 8");

   AST_ILLEGAL_SETS:
      assert property ((i_agp_access_evt && i_agp_outside_aperture &&
                        (i_agp_legacy_hit || i_agp_above_tom))
                       |=> (r_reg.flags[efs_pkg::BIT_IAA] && r_reg.flags[efs_pkg::BIT_OOA]))
      else $error("invalid AGP access did not set bits 3 and 4");

   // An entry fault outside the aperture must not show as bit 2
   AST_ENTRY_INSIDE_ONLY:
      assert property ((!r_reg.flags[efs_pkg::BIT_BTE] &&
                        !(i_agp_access_evt && !i_agp_outside_aperture && i_agp_bad_entry))
                       |=> !r_reg.flags[efs_pkg::BIT_BTE])
      else $error("bit 2 set without a bad entry inside aperture");

   // Cause word only holds enabled flags
   AST_CAUSE_ENABLED:
      assert property ($rose(o_serr_msg_valid) |->
                       ((r_reg.cause & ~$past(i_error_report_enables)) == 16'h0000))
      else $error("cause holds a flag whose report is disabled");

   // An owed message waits for the link instead of being dropped
   AST_QUEUE_HOLDS:
      assert property ((o_serr_msg_valid && !i_serr_msg_ready) |=> o_serr_msg_valid)
      else $error("owed message vanished before the link took it");

   AST_MSG_COUNT:
      assert property (msg_sent |=> (r_reg.msg_cnt == ($past(r_reg.msg_cnt) + 16'h0001)))
      else $error("sent message not counted");

   // ----------------------------------------
   // Register bus checks
   // ----------------------------------------
   AST_MASK_RESERVED:
      assert property ((r_reg.mask & ~efs_pkg::FLAG_IMPL) == 16'h0000)
      else $error("reserved mask bit is set");

   AST_MASK_WRITE:
      assert property ((wr_en && hit(addr, efs_pkg::ADDR_MASK))
                       |=> (r_reg.mask == ($past(wr_data[15:0]) & efs_pkg::FLAG_IMPL)))
      else $error("mask write did not land");

   // Writes to other words touch neither flags nor mask
   AST_UNMAPPED_IGNORED:
      assert property ((wr_en && !hit(addr, efs_pkg::ADDR_STATUS) &&
                        !hit(addr, efs_pkg::ADDR_MASK))
                       |=> ((r_reg.mask == $past(r_reg.mask)) &&
                            ((r_reg.flags & $past(r_reg.flags)) == $past(r_reg.flags))))
      else $error("write to another word changed flags or mask");

   // Status reads never show reserved bits
   AST_READ_RESERVED:
      assert property ((!o_hreadyout && hit(addr, efs_pkg::ADDR_STATUS))
                       |=> ((o_hrdata & ~{16'h0000, efs_pkg::FLAG_IMPL}) == 32'h0000_0000))
      else $error("status read shows a reserved bit");

   // Reads insert exactly one wait state
   AST_ONE_WAIT:
      assert property (!o_hreadyout |=> o_hreadyout)
      else $error("read wait state longer than one cycle");

endmodule

`default_nettype wire

/* bench/efs_link_rx.sv */
`timescale 1ns/1ns
`default_nettype none

// ------
// Hub link receiver model
// ------
module efs_link_rx (
   input wire logic i_core_clk, // Core clock
   input wire logic i_rst_n, // Reset, active low
   input wire logic i_msg_valid, // Message offered
   input wire logic i_slow, // Stall at random
   output logic o_msg_ready, // Takes message
   output logic [15:0] o_count // Messages taken
);
   // A slow link stalls three cycles in four, so owed messages pile up
   always @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_msg_ready <= 1'b0;
         o_count <= 16'h0000;
      end else begin
         o_msg_ready <= !i_slow || ($urandom % 4 == 0);
         if (i_msg_valid && o_msg_ready) begin
            o_count <= o_count + 16'h0001;
         end
      end
   end
endmodule

`default_nettype wire

/* bench/efs_error_flags_tb.sv */
`timescale 1ns/1ns
`default_nettype none

module efs_error_flags_tb;
   // ------
   // Signals and tables
   // ------
   localparam logic [9:0] EV_T [10] = '{10'h001, 10'h006, 10'h002, 10'h008, 10'h030,
      10'h070, 10'h0b0, 10'h110, 10'h010, 10'h200};
   localparam logic [15:0] FL_T [10] = '{16'h0200, 16'h0100, 16'h0000, 16'h0020, 16'h0010,
      16'h0018, 16'h0018, 16'h0004, 16'h0000, 16'h0002};
   localparam logic [31:0] RST_A [5] = '{efs_pkg::ADDR_STATUS, efs_pkg::ADDR_MASK,
      efs_pkg::ADDR_MSG_CNT, efs_pkg::ADDR_CAUSE, 32'h0000_0100};
   logic clk, rst_n, hsel, hwrite, glob, slow;
   logic rd_ph = 1'b0;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic [31:0] haddr, hwdata, m;
   logic [9:0] ev;
   logic [15:0] ena, fl, nmsg;
   wire logic [31:0] hrdata;
   wire logic hready, hresp, valid, ready, irq;
   wire logic [15:0] status, rx_cnt;
   logic [31:0] expq [$];
   int err_total, comparisons, cyc, idx;

   efs_error_flags uut (.i_core_clk(clk), .i_rst_n(rst_n), .i_hsel(hsel), .i_haddr(haddr),
      .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(hsize), .i_hwdata(hwdata),
      .i_hready(hready), .o_hrdata(hrdata), .o_hreadyout(hready), .o_hresp(hresp),
      .i_lock_miss_evt(ev[0]), .i_smi_evt(ev[1]), .i_smi_from_sw(ev[2]),
      .i_special_cycle_evt(ev[3]), .i_agp_access_evt(ev[4]), .i_agp_outside_aperture(ev[5]),
      .i_agp_legacy_hit(ev[6]), .i_agp_above_tom(ev[7]), .i_agp_bad_entry(ev[8]),
      .i_agp_bad_cmd_evt(ev[9]), .i_error_report_enables(ena),
      .i_function_command_serr_en(glob), .o_serr_msg_valid(valid),
      .i_serr_msg_ready(ready), .o_irq(irq), .o_error_flag_status(status));

   efs_link_rx link (.i_core_clk(clk), .i_rst_n(rst_n), .i_msg_valid(valid), .i_slow(slow),
      .o_msg_ready(ready), .o_count(rx_cnt));

   // ------
   // Tasks
   // ------
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         err_total++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic conclude();
      $display("comparisons=%0d err_total=%0d", comparisons, err_total);
      if (err_total == 0 && comparisons > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   // Single transfer; both phases held until hready is seen high
   task automatic bus(input logic [31:0] a, input logic [31:0] d, input logic w,
      input logic [2:0] sz);
      @(posedge clk);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= a;
      hwrite <= w;
      hsize <= sz;
      do @(posedge clk); while (hready !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge clk); while (hready !== 1'b1);
   endtask

   task automatic wr(input logic [31:0] a, input logic [31:0] d);
      bus(a, d, 1'b1, efs_pkg::HSIZE_WORD);
   endtask

   task automatic rd(input logic [31:0] a, input logic [31:0] e);
      expq.push_back(e);
      bus(a, 32'h0000_0000, 1'b0, efs_pkg::HSIZE_WORD);
   endtask

   // One-cycle event pulse, then wait for the link to drain
   task automatic fire(input logic [9:0] e);
      @(posedge clk);
      ev <= e;
      @(posedge clk);
      ev <= 10'h000;
      repeat (3) @(posedge clk);
      for (int k = 0; k < 400 && valid !== 1'b0; k++) @(posedge clk);
      repeat (2) @(posedge clk);
   endtask

   // ------
   // Clock, read monitor and hang guard
   // ------
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   // Read data is taken at the edge that ends the data phase
   always @(posedge clk) begin
      if (rd_ph && hready === 1'b1) begin
         check(hrdata, expq.pop_front());
      end
      if (hsel && htrans[1] && hready && !hwrite) rd_ph <= 1'b1;
      else if (hready) rd_ph <= 1'b0;
   end

   // Ceiling well above the thousand or so cycles the tests take
   always @(posedge clk) begin
      cyc++;
      if (cyc == 40000) begin
         err_total++;
         conclude();
      end
   end

   // ------
   // Main sequence
   // ------
   initial begin
      {rst_n, hsel, hwrite, glob, slow} = 5'h00;
      {htrans, hsize, haddr, hwdata, ev, ena, nmsg} = '0;
      void'($urandom(32'hea22));
      repeat (12) @(posedge clk);
      @(negedge clk) rst_n <= 1'b1;
      foreach (RST_A[i]) rd(RST_A[i], 32'h0000_0000);
      wr(efs_pkg::ADDR_MASK, 32'hffff_ffff);
      rd(efs_pkg::ADDR_MASK, 32'h0000_033e);
      ena <= 16'hffff;
      glob <= 1'b1;
      // Every detector and several qualifier mixes, each cleared afterwards
      for (int i = 0; i < 10; i++) begin
         fire(EV_T[i]);
         if (FL_T[i] != 16'h0000) nmsg++;
         rd(efs_pkg::ADDR_STATUS, {16'h0000, FL_T[i]});
         check(rx_cnt, nmsg);
         check(irq, FL_T[i] != 16'h0000);
         wr(efs_pkg::ADDR_STATUS, 32'hffff_ffff);
         rd(efs_pkg::ADDR_STATUS, 32'h0000_0000);
      end
      // Set flag rising again, then three flags in one cycle
      fire(10'h001);
      fire(10'h001);
      fire(10'h209);
      nmsg += 2;
      check(rx_cnt, nmsg);
      wr(efs_pkg::ADDR_STATUS, 32'h0000_0200);
      wr(efs_pkg::ADDR_STATUS, 32'h0000_0000);
      // Another word written with ones leaves the flags alone
      wr(32'h0000_0100, 32'hffff_ffff);
      check(hresp, {31'h0000_0000, efs_pkg::HRESP_OKAY});
      rd(efs_pkg::ADDR_STATUS, 32'h0000_0022);
      check(status, 16'h0022);
      wr(efs_pkg::ADDR_STATUS, 32'h0000_ffff);
      // Slow link: owed messages drain one by one
      slow <= 1'b1;
      fire(10'h001);
      fire(10'h008);
      fire(10'h200);
      nmsg += 3;
      check(rx_cnt, nmsg);
      rd(efs_pkg::ADDR_MSG_CNT, {16'h0000, nmsg});
      rd(efs_pkg::ADDR_CAUSE, 32'h0000_0002);
      wr(efs_pkg::ADDR_STATUS, 32'h0000_ffff);
      slow <= 1'b0;
      // Random enables, mask and detector: flags set even unreported
      for (int i = 0; i < 30; i++) begin
         m = $urandom;
         idx = $urandom % 10;
         fl = FL_T[idx];
         wr(efs_pkg::ADDR_MASK, m);
         rd(efs_pkg::ADDR_MASK, m & 32'h0000_033e);
         ena <= m[31:16];
         glob <= m[0];
         @(posedge clk);
         fire(EV_T[idx]);
         if (m[0] && (fl & m[31:16]) != 16'h0000) nmsg++;
         check(status, fl);
         check(rx_cnt, nmsg);
         check(irq, (fl & m[15:0] & 16'h033e) != 16'h0000);
         wr(efs_pkg::ADDR_STATUS, {16'h0000, fl});
         // Write lands at this edge; look once it has settled
         @(negedge clk);
         check(status, 16'h0000);
      end
      // Reset in mid-run with flags set: all state returns to zero
      fire(10'h201);
      check(status, 16'h0202);
      rst_n <= 1'b0;
      repeat (2) @(posedge clk);
      @(negedge clk) rst_n <= 1'b1;
      check(status, 16'h0000);
      check(irq, 1'b0);
      rd(efs_pkg::ADDR_MASK, 32'h0000_0000);
      rd(efs_pkg::ADDR_MSG_CNT, 32'h0000_0000);
      conclude();
   end
endmodule

`default_nettype wire
